/* verilog/lcei_regs.svh */
// Register offsets, field positions and reset values of the logic cell block
`ifndef LCEI_REGS_SVH
`define LCEI_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LCEI_OFF_CELL_CTRL   4'h0
`define LCEI_OFF_POLARITY    4'h1
`define LCEI_OFF_SEL0        4'h2
`define LCEI_OFF_SEL1        4'h3
`define LCEI_OFF_SEL2        4'h4
`define LCEI_OFF_SEL3        4'h5
`define LCEI_OFF_GATE0       4'h6
`define LCEI_OFF_GATE1       4'h7
`define LCEI_OFF_GATE2       4'h8
`define LCEI_OFF_GATE3       4'h9
`define LCEI_OFF_MIRROR      4'hA
`define LCEI_OFF_IRQ_CTRL    4'hB
`define LCEI_OFF_PERIPH_IE   4'hC
`define LCEI_OFF_PERIPH_IF   4'hD

// ----------------------------------------
// Cell control, polarity and interrupt control field positions
// ----------------------------------------
`define LCEI_CTRL_ENABLE     7
`define LCEI_CTRL_OUT        5
`define LCEI_CTRL_RISE_IE    4
`define LCEI_CTRL_FALL_IE    3
`define LCEI_POL_OUT         7
`define LCEI_IRQ_GLOBAL      7
`define LCEI_IRQ_PERIPH      6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCEI_RST_CTRL        8'h00
`define LCEI_RST_CFG         8'h00

`endif

/* verilog/lcei_pkg.sv */
// Types shared by the logic cell edge interrupt block
package lcei_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lcei_bus_req_t;

    typedef struct packed {
        logic       enable;
        logic       rise_irq_enable;
        logic       fall_irq_enable;
        logic [2:0] logic_function_select;
        logic [3:0] gate_polarity;
        logic       output_polarity;
    } lcei_cfg_t;

    typedef struct packed {
        logic prev_out;
        logic rise;
        logic fall;
    } lcei_edge_t;

endpackage

/* verilog/lcei_edge_det.sv */
// Rising and falling edge detector watching the cell output
module lcei_edge_det
    import lcei_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Watched level
    input  wire logic enable_i,
    input  wire logic level_i,
    // Edge pulses
    output logic      rise_o,
    output logic      fall_o
);
    import lcei_pkg::*;

    lcei_edge_t st_q;
    lcei_edge_t st_d;

    always_comb
    begin
        st_d          = st_q;
        st_d.prev_out = level_i;
        st_d.rise     = enable_i & level_i & ~st_q.prev_out;
        st_d.fall     = enable_i & ~level_i & st_q.prev_out;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rise_o = st_q.rise;
    assign fall_o = st_q.fall;

    edge_rise_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        rise_o |=> !rise_o) else $error("rise pulse longer than a cycle");

    edge_disabled_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !enable_i |=> !rise_o && !fall_o) else $error("edge while disabled");

endmodule // lcei_edge_det

/* verilog/lcei_gate.sv */
// One data gate: selected inputs masked, ORed and polarity adjusted
module lcei_gate
    import lcei_pkg::*;
(
    // Inputs from the four selectors
    input  wire logic [3:0] data_i,
    // Gate configuration
    input  wire logic [7:0] gate_select_i,
    input  wire logic       gate_polarity_i,
    // Gate result
    output logic            gate_o
);
    import lcei_pkg::*;

    logic [7:0] terms;

    // True and complement of each input, each enabled by one select bit
    always_comb
    begin
        terms  = '0;
        for (int i = 0; i < 4; i++)
        begin
            terms[2*i]   = ~data_i[i] & gate_select_i[2*i];
            terms[2*i+1] = data_i[i] & gate_select_i[2*i+1];
        end
        gate_o = (|terms) ^ gate_polarity_i;
    end

endmodule // lcei_gate

/* verilog/lcei_cell.sv */
// Logic cell with configuration registers and edge interrupt
`include "lcei_regs.svh"

module lcei_cell
    import lcei_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    // Register port
    input  wire lcei_pkg::lcei_bus_req_t bus_i,
    output logic [7:0]                rdata_o,
    // Cell input sources
    input  wire logic [31:0]          sources_i,
    // Cell result and interrupt
    output logic                      cell_output_bit_o,
    output logic                      irq_o
);
    import lcei_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]      ctrl;
        logic [7:0]      pol;
        logic [3:0][4:0] sel;
        logic [3:0][7:0] gls;
        logic [1:0]      irqctl;
        logic            periph_irq_enable_reg;
        logic            flag;
        logic [7:0]      rdata;
        logic            out;
    } lcei_state_t;

    lcei_state_t st_q;
    lcei_state_t st_d;

    logic [3:0] data;
    logic [3:0] gate;
    logic       comb_out;
    logic       rise;
    logic       fall;
    logic       edge_set;
    logic       flag_clr;

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    // four input selectors
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            data[i] = sources_i[st_q.sel[i]];
        end
    end

    for (genvar g = 0; g < 4; g++)
    begin : g_gate
        lcei_gate u_gate (
            .data_i          (data),
            .gate_select_i   (st_q.gls[g]),
            .gate_polarity_i (st_q.pol[g]),
            .gate_o          (gate[g])
        );
    end

    // Function encodings beyond AND/OR/XOR are a simple fixed set
    always_comb
    begin
        case (st_q.ctrl[2:0])
            3'h0:    comb_out = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
            3'h1:    comb_out = ^gate;
            3'h2:    comb_out = &gate;
            3'h3:    comb_out = (gate[0] & gate[1]) | (gate[2] & gate[3]);
            3'h4:    comb_out = |gate;
            3'h5:    comb_out = (gate[0] & gate[1]) ^ (gate[2] & gate[3]);
            3'h6:    comb_out = gate[0] & ~gate[1];
            default: comb_out = gate[0];
        endcase
    end

    lcei_edge_det u_edge (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .enable_i  (st_q.ctrl[`LCEI_CTRL_ENABLE]),
        .level_i   (st_q.out),
        .rise_o    (rise),
        .fall_o    (fall)
    );

    assign edge_set = (rise & st_q.ctrl[`LCEI_CTRL_RISE_IE]) | (fall & st_q.ctrl[`LCEI_CTRL_FALL_IE]);
    assign flag_clr = bus_i.wr && bus_i.addr == `LCEI_OFF_PERIPH_IF && !bus_i.wdata[0];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        st_d = st_q;
        // final output inversion; disabled cell reads low
        st_d.out = st_q.ctrl[`LCEI_CTRL_ENABLE] & (comb_out ^ st_q.pol[`LCEI_POL_OUT]);
        if (bus_i.wr)
        begin
            case (bus_i.addr)
                `LCEI_OFF_CELL_CTRL:  st_d.ctrl   = {bus_i.wdata[7:6], 1'b0, bus_i.wdata[4:0]};
                `LCEI_OFF_POLARITY:   st_d.pol    = {bus_i.wdata[7], 3'h0, bus_i.wdata[3:0]};
                `LCEI_OFF_SEL0:       st_d.sel[0] = bus_i.wdata[4:0];
                `LCEI_OFF_SEL1:       st_d.sel[1] = bus_i.wdata[4:0];
                `LCEI_OFF_SEL2:       st_d.sel[2] = bus_i.wdata[4:0];
                `LCEI_OFF_SEL3:       st_d.sel[3] = bus_i.wdata[4:0];
                `LCEI_OFF_GATE0:      st_d.gls[0] = bus_i.wdata;
                `LCEI_OFF_GATE1:      st_d.gls[1] = bus_i.wdata;
                `LCEI_OFF_GATE2:      st_d.gls[2] = bus_i.wdata;
                `LCEI_OFF_GATE3:      st_d.gls[3] = bus_i.wdata;
                `LCEI_OFF_IRQ_CTRL:   st_d.irqctl = bus_i.wdata[7:6];
                `LCEI_OFF_PERIPH_IE:  st_d.periph_irq_enable_reg    = bus_i.wdata[0];
                default:              st_d.periph_irq_enable_reg    = st_d.periph_irq_enable_reg;
            endcase
        end
        if (flag_clr)
        begin
            st_d.flag = 1'b0;
        end
        if (edge_set)
        begin
            st_d.flag = 1'b1;
        end
        st_d.rdata = '0;
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                `LCEI_OFF_CELL_CTRL:  st_d.rdata = {st_q.ctrl[7:6], st_q.out, st_q.ctrl[4:0]};
                `LCEI_OFF_POLARITY:   st_d.rdata = st_q.pol;
                `LCEI_OFF_SEL0:       st_d.rdata = {3'h0, st_q.sel[0]};
                `LCEI_OFF_SEL1:       st_d.rdata = {3'h0, st_q.sel[1]};
                `LCEI_OFF_SEL2:       st_d.rdata = {3'h0, st_q.sel[2]};
                `LCEI_OFF_SEL3:       st_d.rdata = {3'h0, st_q.sel[3]};
                `LCEI_OFF_GATE0:      st_d.rdata = st_q.gls[0];
                `LCEI_OFF_GATE1:      st_d.rdata = st_q.gls[1];
                `LCEI_OFF_GATE2:      st_d.rdata = st_q.gls[2];
                `LCEI_OFF_GATE3:      st_d.rdata = st_q.gls[3];
                `LCEI_OFF_MIRROR:     st_d.rdata = {7'h00, st_q.out};
                `LCEI_OFF_IRQ_CTRL:   st_d.rdata = {st_q.irqctl, 6'h00};
                `LCEI_OFF_PERIPH_IE:  st_d.rdata = {7'h00, st_q.periph_irq_enable_reg};
                `LCEI_OFF_PERIPH_IF:  st_d.rdata = {7'h00, st_q.flag};
                default:              st_d.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q      <= '0;
            st_q.ctrl <= `LCEI_RST_CTRL;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rdata_o           = st_q.rdata;
    assign cell_output_bit_o = st_q.out;
    assign irq_o = st_q.flag & st_q.periph_irq_enable_reg & st_q.ctrl[`LCEI_CTRL_ENABLE]
                 & st_q.irqctl[1] & st_q.irqctl[0];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    flag_set_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        edge_set |=> st_q.flag) else $error("flag not set by enabled edge");

    set_wins_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        edge_set && flag_clr |=> st_q.flag) else $error("clear beat set");

    flag_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q.flag && !flag_clr |=> st_q.flag) else $error("flag dropped by itself");

    irq_gated_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        irq_o |-> st_q.periph_irq_enable_reg && st_q.irqctl == 2'h3 && st_q.ctrl[`LCEI_CTRL_ENABLE]) else $error("irq ungated");

    rise_gated_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !st_q.flag && !(rise && st_q.ctrl[`LCEI_CTRL_RISE_IE])
        && !(fall && st_q.ctrl[`LCEI_CTRL_FALL_IE]) |=> !st_q.flag)
        else $error("flag set without enabled edge");

    rise_detect_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q.ctrl[`LCEI_CTRL_ENABLE] && $rose(st_q.out) |=> rise) else $error("rise missed");

    out_pol_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $past(st_q.ctrl[`LCEI_CTRL_ENABLE]) |-> st_q.out == ($past(comb_out) ^ $past(st_q.pol[7])))
        else $error("output polarity wrong");

    mirror_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus_i.rd && bus_i.addr == `LCEI_OFF_MIRROR |=> rdata_o[0] == $past(st_q.out))
        else $error("mirror wrong");

    disabled_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !st_q.ctrl[`LCEI_CTRL_ENABLE] |=> !rise && !fall) else $error("edge while disabled");

    // ----------------------------------------
    // Edge, flag, request, output and gate checks
    // ----------------------------------------
    fall_detect_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q.ctrl[`LCEI_CTRL_ENABLE] && $fell(st_q.out) |=> fall)
        else $error("fall missed");

    edge_exclusive_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !(rise && fall))
        else $error("rise and fall together");

    rise_sets_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        rise && st_q.ctrl[`LCEI_CTRL_RISE_IE] |=> st_q.flag)
        else $error("enabled rise did not set flag");

    fall_sets_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        fall && st_q.ctrl[`LCEI_CTRL_FALL_IE] |=> st_q.flag)
        else $error("enabled fall did not set flag");

    clear_alone_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        flag_clr && !edge_set |=> !st_q.flag)
        else $error("flag survived a plain clear");

    irq_raised_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q.flag && st_q.periph_irq_enable_reg && st_q.irqctl == 2'h3 && st_q.ctrl[`LCEI_CTRL_ENABLE] |-> irq_o)
        else $error("request withheld with all enables set");

    irq_needs_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        irq_o |-> st_q.flag)
        else $error("request without flag");

    out_disabled_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !st_q.ctrl[`LCEI_CTRL_ENABLE] |=> !st_q.out)
        else $error("disabled cell output high");

    empty_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q.gls[0] == 8'h00 |-> gate[0] == st_q.pol[0])
        else $error("empty gate not at its polarity");

    // ----------------------------------------
    // Register port checks
    // ----------------------------------------
    mode_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus_i.wr && bus_i.addr == `LCEI_OFF_CELL_CTRL |=> st_q.ctrl[2:0] == $past(bus_i.wdata[2:0]))
        else $error("mode field not stored");

    edge_ie_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus_i.wr && bus_i.addr == `LCEI_OFF_CELL_CTRL |=>
            st_q.ctrl[`LCEI_CTRL_RISE_IE] == $past(bus_i.wdata[`LCEI_CTRL_RISE_IE])
            && st_q.ctrl[`LCEI_CTRL_FALL_IE] == $past(bus_i.wdata[`LCEI_CTRL_FALL_IE]))
        else $error("edge enables not stored");

    sel_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus_i.wr && bus_i.addr == `LCEI_OFF_SEL0 |=> st_q.sel[0] == $past(bus_i.wdata[4:0]))
        else $error("input select not stored");

    gate_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus_i.wr && bus_i.addr == `LCEI_OFF_GATE0 |=> st_q.gls[0] == $past(bus_i.wdata))
        else $error("gate select not stored");

    pol_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus_i.wr && bus_i.addr == `LCEI_OFF_POLARITY |=> st_q.pol[`LCEI_POL_OUT] == $past(bus_i.wdata[`LCEI_POL_OUT]))
        else $error("output polarity not stored");

    ctrl_read_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus_i.rd && bus_i.addr == `LCEI_OFF_CELL_CTRL |=> rdata_o[`LCEI_CTRL_OUT] == $past(st_q.out))
        else $error("control read lost output bit");

    rdata_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");

endmodule // lcei_cell

/* verif/lcei_cell_tb.sv */
// Self-checking bench for the logic cell edge interrupt block
`include "lcei_regs.svh"

module lcei_cell_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lcei_pkg::*;
    // ----------------------------------------
    // Signals and model state
    // ----------------------------------------
    logic          ref_clk_i;
    logic          rst_n_i;
    lcei_bus_req_t bus_i;
    logic [7:0]    rdata_o;
    logic [31:0]   sources_i;
    logic          cell_output_bit_o;
    logic          irq_o;
    int            num_errors;
    int            n_checks;
    int            cycles;
    int            lat;
    logic [7:0]    rd_v;
    logic [7:0]    v;
    logic [7:0]    m_reg [16];

    lcei_cell dut (
        .ref_clk_i         (ref_clk_i),
        .rst_n_i           (rst_n_i),
        .bus_i             (bus_i),
        .rdata_o           (rdata_o),
        .sources_i         (sources_i),
        .cell_output_bit_o (cell_output_bit_o),
        .irq_o             (irq_o)
    );

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    initial
    begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Whole run needs about a thousand cycles
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    // Cell output modelled: four gates and all eight modes
    function automatic logic model_out();
        logic [7:0] g;
        logic [3:0] q;
        logic       r;
        for (int i = 0; i < 4; i++)
        begin
            g[2*i]   = ~sources_i[m_reg[2+i][4:0]];
            g[2*i+1] = sources_i[m_reg[2+i][4:0]];
        end
        for (int j = 0; j < 4; j++)
            q[j] = (|(m_reg[6+j] & g)) ^ m_reg[1][j];
        case (m_reg[0][2:0])
            3'h0:    r = (q[0] | q[1]) ^ (q[2] | q[3]);
            3'h1:    r = q[0] ^ q[1] ^ q[2] ^ q[3];
            3'h2:    r = (q == 4'hF);
            3'h3:    r = (q[0] & q[1]) | (q[2] & q[3]);
            3'h4:    r = (q != 4'h0);
            3'h5:    r = (q[0] & q[1]) ^ (q[2] & q[3]);
            3'h6:    r = q[0] & ~q[1];
            default: r = q[0];
        endcase
        return m_reg[0][7] & (r ^ m_reg[1][7]);
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        m_reg[a] = d;
        @(posedge ref_clk_i);
        bus_i <= '0;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        bus_i <= '0;
        #1;
        chk(n, e, rdata_o);
    endtask

    task automatic src(input logic [31:0] s);
        @(posedge ref_clk_i);
        sources_i <= s;
    endtask

    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst_n_i   = 1'b0;
        bus_i     = '0;
        sources_i = '0;
        void'($urandom(57));
        for (int a = 0; a < 16; a++)
            m_reg[a] = 8'h00;
        do_reset();
        // Reset values, unmapped places read zero
        for (int a = 0; a < 16; a++)
            rchk("reset_read", 4'(a), 8'h00);
        // Register write and read back
        for (int a = 1; a < 13; a++)
        begin
            v = 8'($urandom());
            if (a == 10)
                continue;
            wr(4'(a), v);
            v = v & (a == 1 ? 8'h8F : a < 6 ? 8'h1F : a < 10 ? 8'hFF : a == 11 ? 8'hC0 : 8'h01);
            m_reg[a] = v;
            rchk("cfg_readback", 4'(a), v);
        end
        // Every function code is stored
        for (int m = 0; m < 8; m++)
        begin
            wr(`LCEI_OFF_CELL_CTRL, 8'(m) | 8'h58);
            rchk("mode_field", `LCEI_OFF_CELL_CTRL, 8'(m) | 8'h58);
        end
        // Random selection, gating and polarity in every mode
        for (int t = 0; t < 24; t++)
        begin
            wr(`LCEI_OFF_CELL_CTRL, 8'(t % 8));
            wr(`LCEI_OFF_POLARITY, 8'($urandom()) & 8'h8F);
            for (int j = 0; j < 4; j++)
                wr(4'(6 + j), 8'($urandom()));
            for (int i = 0; i < 4; i++)
                wr(4'(2 + i), 8'($urandom()) & 8'h1F);
            wr(`LCEI_OFF_CELL_CTRL, 8'(t % 8) | 8'h80);
            src($urandom());
            repeat (3) @(posedge ref_clk_i);
            #1;
            chk("cell_out", {7'h00, model_out()}, {7'h00, cell_output_bit_o});
            rchk("mirror", `LCEI_OFF_MIRROR, {7'h00, model_out()});
            rchk("ctrl_out", `LCEI_OFF_CELL_CTRL, 8'(t % 8) | 8'h80 | {2'b00, model_out(), 5'h00});
        end
        // Edge interrupt path, cell output follows source 0
        wr(`LCEI_OFF_CELL_CTRL, 8'h07);
        src(32'h0);
        wr(`LCEI_OFF_POLARITY, 8'h00);
        wr(`LCEI_OFF_SEL0, 8'h00);
        wr(`LCEI_OFF_GATE0, 8'h02);
        wr(`LCEI_OFF_IRQ_CTRL, 8'hC0);
        wr(`LCEI_OFF_PERIPH_IE, 8'h01);
        wr(`LCEI_OFF_CELL_CTRL, 8'h97);
        wr(`LCEI_OFF_PERIPH_IF, 8'h00);
        src(32'h1);
        lat = 0;
        do
        begin
            @(posedge ref_clk_i);
            #1;
            lat++;
        end
        while (irq_o !== 1'b1 && lat < 8);
        chk("rise_irq", 8'h01, {7'h00, irq_o});
        chk("irq_latency", 8'h03, 8'(lat));
        rchk("flag_set", `LCEI_OFF_PERIPH_IF, 8'h01);
        wr(`LCEI_OFF_PERIPH_IF, 8'h00);
        rchk("flag_clr", `LCEI_OFF_PERIPH_IF, 8'h00);
        src(32'h0);
        repeat (6) @(posedge ref_clk_i);
        rchk("fall_gated", `LCEI_OFF_PERIPH_IF, 8'h00);
        wr(`LCEI_OFF_CELL_CTRL, 8'h0F);
        wr(`LCEI_OFF_CELL_CTRL, 8'h8F);
        src(32'h1);
        repeat (6) @(posedge ref_clk_i);
        rchk("rise_gated", `LCEI_OFF_PERIPH_IF, 8'h00);
        src(32'h0);
        repeat (6) @(posedge ref_clk_i);
        rchk("fall_flag", `LCEI_OFF_PERIPH_IF, 8'h01);
        // Each enable alone withholds the request
        for (int e = 0; e < 4; e++)
        begin
            v = m_reg[e == 0 ? 0 : e == 1 ? 12 : 11];
            wr(e == 0 ? 4'h0 : e == 1 ? 4'hC : 4'hB, v & (e == 0 ? 8'h7F : e == 1 ? 8'h00 : e == 2 ? 8'h40 : 8'h80));
            #1;
            chk("irq_masked", 8'h00, {7'h00, irq_o});
            wr(e == 0 ? 4'h0 : e == 1 ? 4'hC : 4'hB, v);
            #1;
            chk("irq_restored", 8'h01, {7'h00, irq_o});
        end
        // Clear landing with the set edge, then one cycle late
        wr(`LCEI_OFF_CELL_CTRL, 8'h97);
        for (int k = 0; k < 2; k++)
        begin
            src(32'h0);
            repeat (6) @(posedge ref_clk_i);
            wr(`LCEI_OFF_PERIPH_IF, 8'h00);
            src(32'h1);
            repeat (lat + k - 1) @(posedge ref_clk_i);
            bus_i <= '{addr: `LCEI_OFF_PERIPH_IF, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
            @(posedge ref_clk_i);
            bus_i <= '0;
            rchk("set_wins", `LCEI_OFF_PERIPH_IF, k == 0 ? 8'h01 : 8'h00);
        end
        // Disabled cell never flags
        wr(`LCEI_OFF_CELL_CTRL, 8'h17);
        src(32'h0);
        repeat (6) @(posedge ref_clk_i);
        src(32'h1);
        repeat (6) @(posedge ref_clk_i);
        rchk("disabled_idle", `LCEI_OFF_PERIPH_IF, 8'h00);
        // Second reset in mid run
        wr(`LCEI_OFF_CELL_CTRL, 8'h97);
        @(posedge ref_clk_i);
        do_reset();
        #1;
        chk("irq_after_rst", 8'h00, {7'h00, irq_o});
        rchk("ctrl_after_rst", `LCEI_OFF_CELL_CTRL, 8'h00);
        end_of_test();
    end
endmodule // lcei_cell_tb
